//--- core/pcer_defs.vh
// Constants for the power control event register bank: offsets,
// field positions, reset values and interrupt bit layout.
// Assumes inclusion by bare name from the design files under core/.
// Behaviour
// - Writing 1 to constant-latency task register triggers constant-latency task.
// - Writing 1 to low-power task register triggers low-power variable-latency task.
// - Constant-latency subscribe holds channel and enable; enabled channel event triggers task.
// - Low-power subscribe holds channel and enable; both reset to zero.
// - Sleep-entry event reads 1 after sleep entered; software may write 0.
// - Sleep-exit event register signals leaving sleep, bit 0 encoding.
// - Publish register selects if and where power-fail warning is broadcast.
// - Publish register selects if and where sleep-entry event is broadcast.
// - Publish register selects if and where sleep-exit event is broadcast.
// - Interrupt enable register plus set and clear companion registers.
// - Register reports whether modem power domain is powered.
// - Two retention registers, read/write, keep contents across system resets.
// - Enable, set and clear registers shared with clock control unit.
`ifndef PCER_DEFS_VH
`define PCER_DEFS_VH

// Register byte offsets
`define PCER_OFS_CONSTANT_LATENCY_TASK   12'h078
`define PCER_OFS_LOW_POWER_VARIABLE_LATENCY_TASK     12'h07C
`define PCER_OFS_CONSTANT_LATENCY_SUB    12'h0F8
`define PCER_OFS_LOW_POWER_VARIABLE_LATENCY_SUB      12'h0FC
`define PCER_OFS_PFW_EVENT       12'h108
`define PCER_OFS_SENTRY_EVENT    12'h114
`define PCER_OFS_SEXIT_EVENT     12'h118
`define PCER_OFS_PFW_PUB         12'h188
`define PCER_OFS_SENTRY_PUB      12'h194
`define PCER_OFS_SEXIT_PUB       12'h198
`define PCER_OFS_INT_ENABLE      12'h300
`define PCER_OFS_INT_ENABLE_SET  12'h304
`define PCER_OFS_INT_ENABLE_CLR  12'h308
`define PCER_OFS_RESET_CAUSE     12'h400
`define PCER_OFS_MODEM_POWER     12'h440
`define PCER_OFS_RETAIN_0        12'h51C
`define PCER_OFS_RETAIN_1        12'h520

// Subscribe and publish fields
`define PCER_CHAN_MSB            4
`define PCER_CHAN_W              5
`define PCER_EN_BIT              31

// Interrupt bit positions
`define PCER_INT_PFW             2
`define PCER_INT_SENTRY          5
`define PCER_INT_SEXIT           6

// Reset values
`define PCER_RST_ZERO            32'h00000000
`define PCER_RST_RETAIN          32'h00000000

`endif

//--- core/pcer_top.v
// Power control event register bank: AHB-Lite slave with tasks,
// subscriptions, events, publications and interrupt enables.
// Assumes one clock mclk, a single AHB-Lite master, and event
// channel fabric and comparator inputs from outside this domain.
//
// Implementation choice: the AHB-Lite slave port.
`include "pcer_defs.vh"
`default_nettype none

module pcer_top (
	// Clock and reset
	input  wire        mclk,
	input  wire        reset,
	// Retention reset, only power-on clears retention words
	input  wire        por_reset,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Event channel fabric, one pulse bit per channel
	input  wire [31:0] channel_events,
	output reg  [31:0] publish_events,
	// Power and processor status, asynchronous
	input  wire        power_fail_below,
	input  wire        sleep_entered,
	input  wire        sleep_exited,
	input  wire        modem_powered,
	input  wire [31:0] reset_cause_flags,
	// Task strobes to the regulator control
	output reg         constant_latency,
	output reg         low_power_variable_latency,
	// Interrupt
	output reg         irq
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	reg [4:0]  sync_a;
	reg [4:0]  sync_b;
	reg [4:0]  sync_c;
	reg [4:0]  stable;
	wire [4:0] raw_in;
	wire [4:0] rise;

	assign raw_in = {modem_powered, sleep_exited, sleep_entered,
		power_fail_below, 1'b0};

	// Three flops; a change counts once second and third agree
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			sync_c <= 5'h00;
			stable <= 5'h00;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
			stable <= (sync_b & sync_c) | (stable & (sync_b | sync_c));
		end
	end

	// Filtered level edges raise the events; a pin must hold its new
	// level for two samples, so a glitch never sets an event
	assign rise = {5{1'b0}} | (({sync_b[4:1] & sync_c[4:1], 1'b0}) &
		~stable);

	// Channel events synchronised the same way, per channel
	reg [31:0] ch_a;
	reg [31:0] ch_b;
	reg [31:0] ch_c;
	reg [31:0] ch_stable;
	wire [31:0] ch_rise;

	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_chan
			always @(posedge mclk or posedge reset) begin
				if (reset) begin
					ch_a[g]      <= 1'b0;
					ch_b[g]      <= 1'b0;
					ch_c[g]      <= 1'b0;
					ch_stable[g] <= 1'b0;
				end else begin
					ch_a[g]      <= channel_events[g];
					ch_b[g]      <= ch_a[g];
					ch_c[g]      <= ch_b[g];
					ch_stable[g] <= (ch_b[g] & ch_c[g]) |
						(ch_stable[g] & (ch_b[g] | ch_c[g]));
				end
			end
			assign ch_rise[g] = ch_b[g] & ch_c[g] & ~ch_stable[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------------------------------
	reg        dp_write;
	reg        dp_read;
	reg [11:0] dp_addr;
	wire       addr_ok;

	// Any size is taken as a whole word: every register is one
	// aligned word, so hsize and the byte lanes are not decoded
	assign addr_ok = hsel && hready && htrans[1];

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			dp_write <= 1'b0;
			dp_read  <= 1'b0;
			dp_addr  <= 12'h000;
		end else begin
			dp_write <= addr_ok && hwrite;
			dp_read  <= addr_ok && !hwrite;
			if (addr_ok)
				dp_addr <= {haddr[11:2], 2'b00};
		end
	end

	wire wr_hit;
	assign wr_hit = dp_write;

	function wr_to;
		input [11:0] ofs;
		begin
			wr_to = wr_hit && (dp_addr == ofs);
		end
	endfunction

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	reg [31:0] constant_latency_sub;
	reg [31:0] low_power_variable_latency_sub;
	reg [31:0] pfw_pub;
	reg [31:0] sentry_pub;
	reg [31:0] sexit_pub;
	reg [31:0] int_enable;
	reg [31:0] reset_cause;
	wire [31:0] sub_mask;
	wire [31:0] int_mask;

	// Only channel index and enable are kept
	assign sub_mask = 32'h8000001F;

	// Enable bits that exist; the rest read back zero
	assign int_mask = (32'h1 << `PCER_INT_PFW) |
		(32'h1 << `PCER_INT_SENTRY) | (32'h1 << `PCER_INT_SEXIT);

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			constant_latency_sub <= `PCER_RST_ZERO;
			low_power_variable_latency_sub   <= `PCER_RST_ZERO;
			pfw_pub      <= `PCER_RST_ZERO;
			sentry_pub   <= `PCER_RST_ZERO;
			sexit_pub    <= `PCER_RST_ZERO;
			int_enable   <= `PCER_RST_ZERO;
		end else begin
			if (wr_to(`PCER_OFS_CONSTANT_LATENCY_SUB))
				constant_latency_sub <= hwdata & sub_mask;
			if (wr_to(`PCER_OFS_LOW_POWER_VARIABLE_LATENCY_SUB))
				low_power_variable_latency_sub <= hwdata & sub_mask;
			if (wr_to(`PCER_OFS_PFW_PUB))
				pfw_pub <= hwdata & sub_mask;
			if (wr_to(`PCER_OFS_SENTRY_PUB))
				sentry_pub <= hwdata & sub_mask;
			if (wr_to(`PCER_OFS_SEXIT_PUB))
				sexit_pub <= hwdata & sub_mask;
			if (wr_to(`PCER_OFS_INT_ENABLE))
				int_enable <= hwdata & int_mask;
			else if (wr_to(`PCER_OFS_INT_ENABLE_SET))
				int_enable <= int_enable | (hwdata & int_mask);
			else if (wr_to(`PCER_OFS_INT_ENABLE_CLR))
				int_enable <= int_enable & ~hwdata;
		end
	end

	// Reset cause latched from flags; write 1 clears, a new flag wins.
	// Only power-on clears it, so software can still read why the
	// last system reset happened
	always @(posedge mclk or posedge por_reset) begin
		if (por_reset)
			reset_cause <= `PCER_RST_ZERO;
		else if (wr_to(`PCER_OFS_RESET_CAUSE))
			reset_cause <= (reset_cause & ~hwdata) | reset_cause_flags;
		else
			reset_cause <= reset_cause | reset_cause_flags;
	end

	reg [31:0] retain [0:1];
	always @(posedge mclk or posedge por_reset) begin
		if (por_reset) begin
			retain[0] <= `PCER_RST_RETAIN;
			retain[1] <= `PCER_RST_RETAIN;
		end else begin
			if (wr_to(`PCER_OFS_RETAIN_0))
				retain[0] <= hwdata;
			if (wr_to(`PCER_OFS_RETAIN_1))
				retain[1] <= hwdata;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	wire sub_cl_hit;
	wire sub_lp_hit;
	wire task_cl;
	wire task_lp;
	wire wr_cl_task;
	wire wr_lp_task;

	// Decoded in full here: a continuous assignment that calls wr_to
	// would only wake on its arguments, never on dp_addr or dp_write
	assign wr_cl_task = wr_hit && (dp_addr == `PCER_OFS_CONSTANT_LATENCY_TASK);
	assign wr_lp_task = wr_hit && (dp_addr == `PCER_OFS_LOW_POWER_VARIABLE_LATENCY_TASK);

	assign sub_cl_hit = constant_latency_sub[`PCER_EN_BIT] &&
		ch_rise[constant_latency_sub[`PCER_CHAN_MSB:0]];
	assign sub_lp_hit = low_power_variable_latency_sub[`PCER_EN_BIT] &&
		ch_rise[low_power_variable_latency_sub[`PCER_CHAN_MSB:0]];
	// write of 1 triggers, 0 ignored
	assign task_cl = (wr_cl_task && hwdata[0]) ||
		sub_cl_hit;
	// write of 1 triggers low-power task
	assign task_lp = (wr_lp_task && hwdata[0]) ||
		sub_lp_hit;

	// One-cycle task strobes
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			constant_latency           <= 1'b0;
			low_power_variable_latency <= 1'b0;
		end else begin
			constant_latency           <= task_cl;
			low_power_variable_latency <= task_lp;
		end
	end

	// ----------------------------------------------------------------
	// Events; hardware set wins over a software clear
	// ----------------------------------------------------------------
	reg pfw_event;
	reg sentry_event;
	reg sexit_event;

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			pfw_event    <= 1'b0;
			sentry_event <= 1'b0;
			sexit_event  <= 1'b0;
		end else begin
			if (rise[1])
				pfw_event <= 1'b1;
			else if (wr_to(`PCER_OFS_PFW_EVENT))
				pfw_event <= hwdata[0];
			if (rise[2])
				sentry_event <= 1'b1;
			else if (wr_to(`PCER_OFS_SENTRY_EVENT))
				sentry_event <= hwdata[0];
			if (rise[3])
				sexit_event <= 1'b1;
			else if (wr_to(`PCER_OFS_SEXIT_EVENT))
				sexit_event <= hwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// Publications and interrupt
	// ----------------------------------------------------------------
	reg [31:0] next_publish;

	// Each published event pulses its chosen channel for one cycle
	always @* begin
		next_publish = 32'h00000000;
		if (rise[1] && pfw_pub[`PCER_EN_BIT])
			next_publish[pfw_pub[`PCER_CHAN_MSB:0]] = 1'b1;
		if (rise[2] && sentry_pub[`PCER_EN_BIT])
			next_publish[sentry_pub[`PCER_CHAN_MSB:0]] = 1'b1;
		if (rise[3] && sexit_pub[`PCER_EN_BIT])
			next_publish[sexit_pub[`PCER_CHAN_MSB:0]] = 1'b1;
	end

	wire [31:0] event_vec;
	assign event_vec = ({31'h0, pfw_event} << `PCER_INT_PFW) |
		({31'h0, sentry_event} << `PCER_INT_SENTRY) |
		({31'h0, sexit_event} << `PCER_INT_SEXIT);

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			publish_events <= 32'h00000000;
			irq            <= 1'b0;
		end else begin
			publish_events <= next_publish;
			irq <= |(event_vec & int_enable);
		end
	end

	// ----------------------------------------------------------------
	// Read data and response
	// ----------------------------------------------------------------
	reg [31:0] next_rdata;

	always @* begin
		case (dp_addr)
		`PCER_OFS_CONSTANT_LATENCY_SUB:   next_rdata = constant_latency_sub;
		`PCER_OFS_LOW_POWER_VARIABLE_LATENCY_SUB:     next_rdata = low_power_variable_latency_sub;
		`PCER_OFS_PFW_EVENT:      next_rdata = {31'h0, pfw_event};
		`PCER_OFS_SENTRY_EVENT:   next_rdata = {31'h0, sentry_event};
		`PCER_OFS_SEXIT_EVENT:    next_rdata = {31'h0, sexit_event};
		`PCER_OFS_PFW_PUB:        next_rdata = pfw_pub;
		`PCER_OFS_SENTRY_PUB:     next_rdata = sentry_pub;
		`PCER_OFS_SEXIT_PUB:      next_rdata = sexit_pub;
		`PCER_OFS_INT_ENABLE:     next_rdata = int_enable;
		`PCER_OFS_INT_ENABLE_SET: next_rdata = int_enable;
		`PCER_OFS_INT_ENABLE_CLR: next_rdata = int_enable;
		`PCER_OFS_RESET_CAUSE:    next_rdata = reset_cause;
		`PCER_OFS_MODEM_POWER:    next_rdata = {31'h0, stable[4]};
		`PCER_OFS_RETAIN_0:       next_rdata = retain[0];
		`PCER_OFS_RETAIN_1:       next_rdata = retain[1];
		// Tasks and holes read zero
		default:                  next_rdata = 32'h00000000;
		endcase
	end

	// Reads insert one wait state so hrdata comes straight from a
	// flop; writes finish without waiting
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok && !hwrite) begin
				hreadyout <= 1'b0;
			end
			if (dp_read) begin
				hrdata    <= next_rdata;
				hreadyout <= 1'b1;
			end
		end
	end

endmodule // pcer_top

`default_nettype wire

//--- test/pcer_props.sv
// Checker for the power control event register bank ports.
// Assumes one clock mclk and async active high reset.
`default_nettype none
module pcer_props (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Tasks and interrupt
	input wire logic        constant_latency,
	input wire logic        low_power_variable_latency,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// Accepted address phase
	wire logic take = hsel && hready && htrans[1];
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_const_task: assert property (take && hwrite && haddr[11:0] == 12'h078 ##1 hwdata[0] |-> ##[1:3] constant_latency) else $error("constant latency task missing");
	a_low_task: assert property (take && hwrite && haddr[11:0] == 12'h07C ##1 hwdata[0] |-> ##[1:3] low_power_variable_latency) else $error("low power task missing");
	a_irq_all_masked: assert property (take && hwrite && haddr[11:0] == 12'h308 ##1 hwdata == 32'hFFFFFFFF |-> ##[1:3] !irq) else $error("irq with all enables off");
	a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
	a_unmapped_zero: assert property (take && !hwrite && haddr[11:0] == 12'h004 |=> ##1 hrdata == 32'h00000000) else $error("unmapped read not zero");
	a_wait_short: assert property (!hreadyout |=> hreadyout) else $error("wait longer than one cycle");
	a_write_no_wait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	cover property (constant_latency);
	cover property (low_power_variable_latency);
	cover property (irq ##1 !irq);
endmodule // pcer_props
bind pcer_top pcer_props u_props (.mclk(mclk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.constant_latency(constant_latency),
	.low_power_variable_latency(low_power_variable_latency), .irq(irq));
`default_nettype wire

//--- test/pcer_fabric.sv
// Event channel fabric model: raises one channel level on request.
// Assumes the bench asks for a channel just after a rising edge.
`default_nettype none
module pcer_fabric (
	// Clock
	input wire logic        mclk,
	// Request from the bench
	input wire logic        fire,
	input wire logic [4:0]  fire_ch,
	// Channel levels
	output logic     [31:0] channel_events
);
	timeunit 1ns;
	timeprecision 1ps;
	// Levels settle to zero on the first edge, well inside reset
	logic [3:0] hold = 4'h0;
	// channel event level
	// Held several cycles so the three-flop filter sees it
	always @(posedge mclk) begin
		if (fire) begin
			channel_events <= 32'h00000001 << fire_ch;
			hold <= 4'h6;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end else begin
			channel_events <= 32'h00000000;
		end
	end
endmodule // pcer_fabric
`default_nettype wire

//--- test/pcer_top_tb.sv
// Testbench for the power control event register bank.
// Assumes the checker is bound and the fabric model drives channels.
`default_nettype none
module pcer_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset, por_reset, hsel, hwrite, fire, modem_powered;
	logic [31:0] haddr, hwdata, rd, d, failures, samples_checked;
	logic [31:0] n_cl, n_lp, n_pub;
	logic [1:0]  htrans;
	logic [2:0]  hsize, stat;
	logic [4:0]  fire_ch, ch;
	logic [11:0] rw_ofs [7] = '{12'h0F8, 12'h0FC, 12'h188, 12'h194,
		12'h198, 12'h51C, 12'h520};
	logic [11:0] ev_ofs [3] = '{12'h108, 12'h114, 12'h118};
	logic [31:0] rw_exp [7];
	wire logic [31:0] hrdata, publish_events, channel_events;
	wire logic hreadyout, hresp, constant_latency, low_power_variable_latency;
	wire logic irq;
	pcer_top u_dut (.mclk(mclk), .reset(reset), .por_reset(por_reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.channel_events(channel_events), .publish_events(publish_events),
		.power_fail_below(stat[0]), .sleep_entered(stat[1]),
		.sleep_exited(stat[2]), .modem_powered(modem_powered),
		.reset_cause_flags(32'h00000000), .constant_latency(constant_latency),
		.low_power_variable_latency(low_power_variable_latency), .irq(irq));
	pcer_fabric u_fab (.mclk(mclk), .fire(fire), .fire_ch(fire_ch),
		.channel_events(channel_events));
	always #2.5 mclk = ~mclk;
	// Pulse counters, cleared by reset; a stuck pulse overcounts
	always @(posedge mclk) begin
		if (reset) begin
			n_cl <= 32'h00000000;
			n_lp <= 32'h00000000;
			n_pub <= 32'h00000000;
		end else begin
			n_cl <= n_cl + (constant_latency === 1'b1);
			n_lp <= n_lp + (low_power_variable_latency === 1'b1);
			n_pub <= n_pub + (publish_events[ch] === 1'b1);
		end
	end
	// -------------------------------------------------------------
	// Bus cycles and comparison
	// -------------------------------------------------------------
	task bus(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= v;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task pulse_ch(input logic [4:0] c);
		@(posedge mclk);
		fire <= 1'b1;
		fire_ch <= c;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (14) @(posedge mclk);
	endtask
	task test_done;
		$display("failures %0d checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked != 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard, well beyond the few hundred cycles used
	initial begin
		#100000;
		failures = failures + 1;
		test_done;
	end
	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		{mclk, hsel, hwrite, fire, modem_powered, stat} = 0;
		{haddr, hwdata, failures, samples_checked} = 0;
		{htrans, fire_ch, ch} = 0;
		hsize = 3'h2;
		reset = 1'b1;
		por_reset = 1'b1;
		void'($urandom(32'h5294));
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		// Random write then readback; config fields are bits 31 and 4:0
		for (int i = 0; i < 7; i++) begin
			d = $urandom;
			rw_exp[i] = (i > 4) ? d : d & 32'h8000001F;
			bus(1'b1, rw_ofs[i], d);
			bus(1'b0, rw_ofs[i], 32'h00000000);
			chk(rd, rw_exp[i]);
		end
		// System reset clears config but keeps retention words
		@(posedge mclk) reset <= 1'b1;
		@(posedge mclk) reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, rw_ofs[i], 32'h00000000);
			chk(rd, (i > 4) ? rw_exp[i] : 32'h00000000);
		end
		// Task by write 0, write 1, enabled and disabled subscription
		for (int t = 0; t < 2; t++) begin
			bus(1'b1, t ? 12'h07C : 12'h078, $urandom & 32'hFFFFFFFE);
			bus(1'b1, t ? 12'h07C : 12'h078, 32'h00000001);
			d = $urandom;
			bus(1'b1, t ? 12'h0FC : 12'h0F8, {1'b1, 26'h0, d[4:0]});
			pulse_ch(d[4:0]);
			bus(1'b1, t ? 12'h0FC : 12'h0F8, {27'h0, d[4:0]});
			pulse_ch(d[4:0]);
		end
		chk(n_cl, 32'h00000002);
		chk(n_lp, 32'h00000002);
		// Each event sets, publishes once, raises irq and clears
		bus(1'b1, 12'h304, 32'h00000064);
		for (int e = 0; e < 3; e++) begin
			d = $urandom;
			// Publish setups sit at entries 2 to 4 of rw_ofs
			bus(1'b1, rw_ofs[e + 2], {1'b1, 26'h0, d[4:0]});
			ch = d[4:0];
			stat[e] <= 1'b1;
			repeat (10) @(posedge mclk);
			stat[e] <= 1'b0;
			repeat (4) @(posedge mclk);
			bus(1'b0, ev_ofs[e], 32'h00000000);
			chk(rd, 32'h00000001);
			chk({31'h0, irq}, 32'h00000001);
			chk(n_pub, e + 1);
			bus(1'b1, ev_ofs[e], 32'h00000000);
			repeat (3) @(posedge mclk);
			chk({31'h0, irq}, 32'h00000000);
		end
		// Enable readback, clear one bit, masked event keeps irq low
		bus(1'b0, 12'h300, 32'h00000000);
		chk(rd, 32'h00000064);
		bus(1'b1, 12'h308, 32'h00000020);
		bus(1'b0, 12'h300, 32'h00000000);
		chk(rd, 32'h00000044);
		stat[1] <= 1'b1;
		repeat (10) @(posedge mclk);
		stat[1] <= 1'b0;
		chk({31'h0, irq}, 32'h00000000);
		bus(1'b1, 12'h308, 32'hFFFFFFFF);
		// Modem domain status and an unmapped hole
		modem_powered <= 1'b1;
		repeat (4) @(posedge mclk);
		bus(1'b0, 12'h440, 32'h00000000);
		chk({31'h0, rd[0]}, 32'h00000001);
		bus(1'b0, 12'h004, 32'h00000000);
		chk(rd, 32'h00000000);
		test_done;
	end
endmodule // pcer_top_tb
`default_nettype wire
